//--- hw/rgw_defs.svh
`ifndef RGW_DEFS_SVH
`define RGW_DEFS_SVH

// general purpose timer count width, in crystal-domain clock cycles
`define RGW_GPT_W 16
// general purpose timer counter value after reset
`define RGW_GPT_CNT_RST 16'h0000

// wake-up timer interval select width and counter width
`define RGW_WUT_SEL_W 3
`define RGW_WUT_CNT_W 24
// shortest wake-up interval, in low power oscillator ticks
`define RGW_WUT_BASE_TICKS 24'h000010
// wake-up timer counter value after reset
`define RGW_WUT_CNT_RST 24'h000000

// positions of the expiry flags in the flag vector
`define RGW_FLAG_GPT 0
`define RGW_FLAG_WUT 1
`define RGW_NFLAGS 2
// flag vector value after reset
`define RGW_FLAGS_RST 2'h0

`endif

//--- hw/rgw_pkg.sv
package rgw_pkg;

    // operating mode supplied by the mode controller
    typedef enum logic [1:0] {
        RGW_MODE_NORMAL = 2'h0,
        RGW_MODE_WAKEUP = 2'h1,
        RGW_MODE_LOW_POWER = 2'h2,
        RGW_MODE_P2P_ACTIVE = 2'h3
    } rgw_mode_t;

    // hardware trigger source of the general purpose timer
    typedef enum logic [1:0] {
        RGW_TRIG_NONE = 2'h0,
        RGW_TRIG_SOF = 2'h1,
        RGW_TRIG_EOF = 2'h2,
        RGW_TRIG_FIELD_OFF = 2'h3
    } rgw_trig_t;

    // general purpose timer states, gray coded along idle-run-expire
    typedef enum logic [1:0] {
        RGW_GPT_IDLE = 2'h0,
        RGW_GPT_RUN = 2'h1,
        RGW_GPT_EXPIRE = 2'h3
    } rgw_gpt_state_t;

endpackage : rgw_pkg

//--- hw/rgw_timers.sv
// Contract
// - sof trigger starts general purpose timer
// - eof trigger starts general purpose timer
// - p2p field-off times out via timer
// - every general purpose expiry sets its flag, interrupt unless masked
// - start command restarts a running timer
// - wake timer paces wake-up mode activity
// - wake start command ignored in wake-up
// - start enables rc oscillator, selected interval
// - wake expiry sets flag, and interrupt unless masked
// - wake timer keeps counting in low power
// - clear command stops all but wake
`timescale 1ns/1ns
`include "rgw_defs.svh"

module rgw_timers #(
    parameter int unsigned GPT_W = `RGW_GPT_W,
    parameter logic [`RGW_WUT_CNT_W-1:0] WUT_BASE_TICKS = `RGW_WUT_BASE_TICKS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire rgw_pkg::rgw_mode_t op_mode,
    input wire logic xtal_ok,
    input wire logic rc_tick,
    input wire rgw_pkg::rgw_trig_t gpt_trig_sel,
    input wire logic [GPT_W-1:0] gpt_period,
    input wire logic [`RGW_WUT_SEL_W-1:0] wut_sel,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic field_off_start,
    input wire logic cmd_start_gpt,
    input wire logic cmd_start_wut,
    input wire logic cmd_clear,
    input wire logic irq_read,
    input wire logic [`RGW_NFLAGS-1:0] irq_mask,
    output logic irq,
    output logic gpt_expired_flag,
    output logic wake_timer_expired_flag,
    output logic gpt_running,
    output logic [GPT_W-1:0] gpt_count,
    output logic wut_running,
    output logic rc_osc_en,
    output logic wake_cycle_tick
);

    rgw_wake_if wif ();

    rgw_pkg::rgw_gpt_state_t gpt_state_r;
    rgw_pkg::rgw_gpt_state_t gpt_state_nxt;
    logic [GPT_W-1:0] gpt_cnt_r;
    logic [GPT_W-1:0] gpt_cnt_nxt;
    logic [`RGW_NFLAGS-1:0] flags_r;
    logic [`RGW_NFLAGS-1:0] flags_nxt;
    logic [`RGW_NFLAGS-1:0] flag_set;
    logic in_wake_r;
    logic wake_tick_r;

    logic in_wake;
    logic wake_entry;
    logic wake_exit;
    logic wut_cmd_ok;
    logic trig_sof;
    logic trig_eof;
    logic trig_field;
    logic gpt_trig;
    logic gpt_tick;
    logic gpt_last;
    logic gpt_expire;

    // mode decode and wake timer control
    assign in_wake = (op_mode == rgw_pkg::RGW_MODE_WAKEUP);
    assign wake_entry = in_wake & ~in_wake_r;
    assign wake_exit = ~in_wake & in_wake_r;
    assign wut_cmd_ok = cmd_start_wut & ~in_wake;
    assign wif.start = wut_cmd_ok | wake_entry;
    assign wif.stop = wake_exit;
    assign wif.periodic = in_wake;
    assign wif.sel = wut_sel;

    // hardware trigger selection for the general purpose timer
    assign trig_sof = (gpt_trig_sel == rgw_pkg::RGW_TRIG_SOF) & rx_sof;
    assign trig_eof = (gpt_trig_sel == rgw_pkg::RGW_TRIG_EOF) & rx_eof;
    assign trig_field = (gpt_trig_sel == rgw_pkg::RGW_TRIG_FIELD_OFF)
        & (op_mode == rgw_pkg::RGW_MODE_P2P_ACTIVE) & field_off_start;
    assign gpt_trig = trig_sof | trig_eof | trig_field | cmd_start_gpt;

    // counts only while the crystal runs; stopped in low power mode
    assign gpt_tick = xtal_ok & (op_mode != rgw_pkg::RGW_MODE_LOW_POWER);
    assign gpt_last = gpt_cnt_r <= GPT_W'(1);
    assign gpt_expire = (gpt_state_r == rgw_pkg::RGW_GPT_EXPIRE);

    // general purpose timer next state; clear beats start
    always_comb begin
        gpt_state_nxt = gpt_state_r;
        gpt_cnt_nxt = gpt_cnt_r;
        unique case (gpt_state_r)
            rgw_pkg::RGW_GPT_IDLE: begin
                if (gpt_trig) begin
                    gpt_state_nxt = rgw_pkg::RGW_GPT_RUN;
                    gpt_cnt_nxt = gpt_period;
                end
            end
            rgw_pkg::RGW_GPT_RUN: begin
                if (gpt_trig) begin
                    gpt_cnt_nxt = gpt_period;
                end else if (gpt_tick && gpt_last) begin
                    gpt_state_nxt = rgw_pkg::RGW_GPT_EXPIRE;
                    gpt_cnt_nxt = GPT_W'(0);
                end else if (gpt_tick) begin
                    gpt_cnt_nxt = gpt_cnt_r - GPT_W'(1);
                end
            end
            rgw_pkg::RGW_GPT_EXPIRE: begin
                if (gpt_trig) begin
                    gpt_state_nxt = rgw_pkg::RGW_GPT_RUN;
                    gpt_cnt_nxt = gpt_period;
                end else begin
                    gpt_state_nxt = rgw_pkg::RGW_GPT_IDLE;
                end
            end
            default: begin
                gpt_state_nxt = rgw_pkg::RGW_GPT_IDLE;
                gpt_cnt_nxt = GPT_W'(`RGW_GPT_CNT_RST);
            end
        endcase
        if (cmd_clear) begin
            gpt_state_nxt = rgw_pkg::RGW_GPT_IDLE;
            gpt_cnt_nxt = GPT_W'(`RGW_GPT_CNT_RST);
        end
    end

    // sticky expiry flags; a new event beats the read that clears
    assign flag_set[`RGW_FLAG_GPT] = gpt_expire;
    assign flag_set[`RGW_FLAG_WUT] = wif.expire;
    assign flags_nxt = flag_set | (flags_r & ~{`RGW_NFLAGS{irq_read}});

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gpt_state_r <= rgw_pkg::RGW_GPT_IDLE;
            gpt_cnt_r <= GPT_W'(`RGW_GPT_CNT_RST);
            flags_r <= `RGW_FLAGS_RST;
            in_wake_r <= 1'b0;
            wake_tick_r <= 1'b0;
        end else if (clk_en) begin
            gpt_state_r <= gpt_state_nxt;
            gpt_cnt_r <= gpt_cnt_nxt;
            flags_r <= flags_nxt;
            in_wake_r <= in_wake;
            wake_tick_r <= wif.expire & in_wake;
        end
    end

    // outputs
    assign irq = |(flags_r & ~irq_mask);
    assign gpt_expired_flag = flags_r[`RGW_FLAG_GPT];
    assign wake_timer_expired_flag = flags_r[`RGW_FLAG_WUT];
    assign gpt_running = (gpt_state_r == rgw_pkg::RGW_GPT_RUN);
    assign gpt_count = gpt_cnt_r;
    assign wut_running = wif.running;
    assign rc_osc_en = wif.running;
    assign wake_cycle_tick = wake_tick_r;

    // wake-up timer core on low power oscillator ticks
    rgw_wake_timer #(
        .BASE_TICKS(WUT_BASE_TICKS)
    ) u_wake (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .rc_tick(rc_tick),
        .wif(wif)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sof_start_a: assert property (
        (clk_en && trig_sof && !cmd_clear)
        |=> (gpt_running && gpt_cnt_r == $past(gpt_period)))
        else $error("sof trigger did not start the timer");

    eof_start_a: assert property (
        (clk_en && trig_eof && !cmd_clear)
        |=> (gpt_running && gpt_cnt_r == $past(gpt_period)))
        else $error("eof trigger did not start the timer");

    field_off_a: assert property (
        (clk_en && field_off_start && !cmd_clear
            && gpt_trig_sel == rgw_pkg::RGW_TRIG_FIELD_OFF
            && op_mode == rgw_pkg::RGW_MODE_P2P_ACTIVE)
        |=> gpt_running)
        else $error("field-off trigger did not start the timer");

    gpt_irq_a: assert property (
        (clk_en && gpt_expire) |=> (gpt_expired_flag && (irq || irq_mask[0])))
        else $error("timer expiry raised no interrupt");

    gpt_restart_a: assert property (
        (clk_en && gpt_running && cmd_start_gpt && !cmd_clear)
        |=> (gpt_running && gpt_cnt_r == $past(gpt_period)))
        else $error("start command did not restart the running timer");

    wut_ignore_a: assert property (
        (in_wake && in_wake_r && cmd_start_wut) |-> !wif.start)
        else $error("wake start command accepted in wake-up mode");

    wut_osc_a: assert property (
        (clk_en && wut_cmd_ok) |=> (rc_osc_en && wut_running))
        else $error("wake start did not enable the oscillator");

    wut_flag_a: assert property (
        (clk_en && wif.expire) |=> wake_timer_expired_flag)
        else $error("wake expiry did not set its flag");

    clear_stop_a: assert property (
        (clk_en && cmd_clear && wut_running && !wif.stop && !rc_tick)
        |=> (!gpt_running && !gpt_expire && wut_running))
        else $error("clear command stopped the wrong timers");

    flag_hold_a: assert property (
        (clk_en && !irq_read && flags_r != 2'h0)
        |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("expiry flag dropped without a read");

    // general purpose timer counting, pausing and refusing
    gpt_idle_hold_a: assert property (
        (clk_en && !gpt_running && !gpt_trig) |=> !gpt_running)
        else $error("timer started without a trigger");

    field_refuse_a: assert property (
        (clk_en && !gpt_running && field_off_start && !trig_sof && !trig_eof
            && !cmd_start_gpt && op_mode != rgw_pkg::RGW_MODE_P2P_ACTIVE)
        |=> !gpt_running)
        else $error("field-off trigger started the timer outside peer mode");

    gpt_count_a: assert property (
        (clk_en && gpt_running && gpt_tick && !gpt_last && !gpt_trig && !cmd_clear)
        |=> (gpt_running && gpt_cnt_r == $past(gpt_cnt_r) - GPT_W'(1)))
        else $error("timer missed a counting cycle");

    gpt_timeout_a: assert property (
        (clk_en && gpt_running && gpt_tick && gpt_last && !gpt_trig && !cmd_clear)
        |=> gpt_expire)
        else $error("timer did not expire at the end of its period");

    gpt_expire_once_a: assert property (
        (clk_en && gpt_expire && !gpt_trig && !cmd_clear)
        |=> (gpt_state_r == rgw_pkg::RGW_GPT_IDLE))
        else $error("expiry lasted more than one cycle");

    gpt_pause_a: assert property (
        (clk_en && gpt_running && !gpt_tick && !gpt_trig && !cmd_clear)
        |=> (gpt_running && gpt_cnt_r == $past(gpt_cnt_r)))
        else $error("timer counted without the crystal");

    clear_wins_a: assert property (
        (clk_en && cmd_clear)
        |=> (gpt_state_r == rgw_pkg::RGW_GPT_IDLE && gpt_cnt_r == GPT_W'(`RGW_GPT_CNT_RST)))
        else $error("clear command left the timer running");

    freeze_hold_a: assert property (
        (!clk_en)
        |=> (gpt_state_r == $past(gpt_state_r) && gpt_cnt_r == $past(gpt_cnt_r)
            && flags_r == $past(flags_r) && in_wake_r == $past(in_wake_r)))
        else $error("state moved while the clock enable was low");

    // wake-up timer control
    wake_entry_a: assert property (
        (clk_en && wake_entry) |=> wut_running)
        else $error("entering wake-up mode did not start the wake timer");

    wake_exit_a: assert property (
        (clk_en && wake_exit && !cmd_start_wut) |=> !wut_running)
        else $error("leaving wake-up mode did not stop the wake timer");

    wake_tick_a: assert property (
        (clk_en && wif.expire && in_wake) |=> wake_cycle_tick)
        else $error("wake-up cycle tick missing on expiry");

    // flags and interrupt line
    flag_clear_a: assert property (
        (clk_en && irq_read && !gpt_expire && !wif.expire)
        |=> (!gpt_expired_flag && !wake_timer_expired_flag))
        else $error("interrupt read left a flag set");

    gpt_irq_on_a: assert property (
        (gpt_expired_flag && !irq_mask[0]) |-> irq)
        else $error("unmasked timer flag without interrupt");

    wut_irq_on_a: assert property (
        (wake_timer_expired_flag && !irq_mask[1]) |-> irq)
        else $error("unmasked wake flag without interrupt");

    irq_quiet_a: assert property (
        (!gpt_expired_flag && !wake_timer_expired_flag) |-> !irq)
        else $error("interrupt raised with no flag set");

endmodule : rgw_timers

//--- hw/rgw_wake_if.sv
`timescale 1ns/1ns
`include "rgw_defs.svh"

// control path between the timer top and the wake-up timer core
interface rgw_wake_if;
    logic start;
    logic stop;
    logic periodic;
    logic [`RGW_WUT_SEL_W-1:0] sel;
    logic expire;
    logic running;

    modport ctrl (output start, output stop, output periodic, output sel,
                  input expire, input running);
    modport timer (input start, input stop, input periodic, input sel,
                   output expire, output running);
endinterface : rgw_wake_if

//--- hw/rgw_wake_timer.sv
`timescale 1ns/1ns
`include "rgw_defs.svh"

module rgw_wake_timer #(
    parameter logic [`RGW_WUT_CNT_W-1:0] BASE_TICKS = `RGW_WUT_BASE_TICKS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic rc_tick,
    rgw_wake_if.timer wif
);

    // interval in oscillator ticks: base doubled per select step
    function automatic logic [`RGW_WUT_CNT_W-1:0] wut_limit(
        input logic [`RGW_WUT_SEL_W-1:0] sel
    );
        wut_limit = BASE_TICKS << sel;
    endfunction : wut_limit

    logic run_r;
    logic expire_r;
    logic [`RGW_WUT_CNT_W-1:0] cnt_r;
    logic hit;
    logic [`RGW_WUT_CNT_W-1:0] limit;

    // last tick of the interval; counts only on oscillator ticks
    assign hit = run_r & rc_tick & (cnt_r <= `RGW_WUT_CNT_W'(1));
    assign limit = wut_limit(wif.sel);
    assign wif.expire = expire_r;
    assign wif.running = run_r;

    // counter; start reloads, periodic mode reloads on expiry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
            expire_r <= 1'b0;
            cnt_r <= `RGW_WUT_CNT_RST;
        end else if (clk_en) begin
            expire_r <= hit;
            if (wif.start) begin
                run_r <= 1'b1;
                cnt_r <= limit;
            end else if (wif.stop) begin
                run_r <= 1'b0;
            end else if (hit) begin
                run_r <= wif.periodic;
                cnt_r <= limit;
            end else if (run_r && rc_tick) begin
                cnt_r <= cnt_r - `RGW_WUT_CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    wut_start_on_a: assert property (
        (clk_en && wif.start) |=> (run_r && cnt_r == $past(limit)))
        else $error("wake timer did not load its interval on start");

    wut_counts_a: assert property (
        (clk_en && run_r && rc_tick && !wif.start && !wif.stop && !hit)
        |=> (cnt_r == $past(cnt_r) - `RGW_WUT_CNT_W'(1)))
        else $error("wake timer missed an oscillator tick");

    wut_periodic_a: assert property (
        (clk_en && hit && wif.periodic && !wif.start && !wif.stop)
        |=> (run_r && expire_r))
        else $error("periodic wake timer did not reload on expiry");

endmodule : rgw_wake_timer

//--- testbench/reader_gp_and_wake_timers_test.sv
`timescale 1ns/1ns
module reader_gp_and_wake_timers_test;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, xtal_ok = 1'b1, rc_tick = 1'b0;
    logic rx_sof = 1'b0, rx_eof = 1'b0, field_off_start = 1'b0, go = 1'b0, ack_en = 1'b1;
    logic cmd_start_gpt, cmd_start_wut, cmd_clear, irq_read, gp = 1'b0, wp = 1'b0;
    rgw_pkg::rgw_mode_t op_mode = rgw_pkg::RGW_MODE_NORMAL;
    rgw_pkg::rgw_trig_t gpt_trig_sel = rgw_pkg::RGW_TRIG_NONE;
    logic [15:0] gpt_period = 16'h0003, gpt_count, p;
    logic [2:0] wut_sel = 3'h0;
    logic [1:0] irq_mask = 2'h0, op = 2'h0;
    logic irq, gpt_expired_flag, wake_timer_expired_flag, gpt_running, wut_running;
    logic rc_osc_en, wake_cycle_tick;
    int error_cnt = 0, comparisons = 0, cyc = 0, wt = 0, k, e, seed = 32'h05fbac36;
    int gq[$], wq[$];

    rgw_timers #(.WUT_BASE_TICKS(24'h000004)) DUT (.clk, .arst_n, .clk_en, .op_mode,
        .xtal_ok, .rc_tick, .gpt_trig_sel, .gpt_period, .wut_sel, .rx_sof, .rx_eof,
        .field_off_start, .cmd_start_gpt, .cmd_start_wut, .cmd_clear, .irq_read, .irq_mask,
        .irq, .gpt_expired_flag, .wake_timer_expired_flag, .gpt_running, .gpt_count,
        .wut_running, .rc_osc_en, .wake_cycle_tick);
    rgw_ctrl_model ctrl (.clk, .arst_n, .go, .op, .ack_en, .irq, .cmd_start_gpt,
        .cmd_start_wut, .cmd_clear, .irq_read);

    initial forever #25 clk = ~clk;

    task check(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // controller request through the model; take edge is k+2
    task cmd(logic [1:0] c);
        @(posedge clk) go <= 1'b1;
        op <= c;
        k = cyc;
        @(posedge clk) go <= 1'b0;
    endtask : cmd

    // framing event pulse, taken at k+2
    task rx(int w);
        @(posedge clk) k = cyc;
        @(posedge clk) {field_off_start, rx_eof, rx_sof} <= 3'(1 << (w - 1));
        @(posedge clk) {field_off_start, rx_eof, rx_sof} <= 3'h0;
    endtask : rx

    task pump(int n);
        repeat (n) begin
            @(posedge clk) rc_tick <= 1'b1;
            @(posedge clk) rc_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : pump

    // bounded wait until every noted expiry was seen
    task drain;
        for (int i = 0; i < 300 && gq.size() + wq.size() > 0; i++) @(posedge clk);
        if (gq.size() + wq.size() > 0) begin
            error_cnt++;
            finish_test();
        end
    endtask : drain

    // cycle count, advanced on the edge that the design samples
    always @(posedge clk) cyc <= cyc + 1;

    // expiry watcher: compares each flag rise with the oldest note, off the edge
    always @(negedge clk) begin
        if (gpt_expired_flag && !gp) begin
            e = gq.size() > 0 ? gq.pop_front() : -1;
            check(16'(cyc), 16'(e));
            check(16'(irq), 16'(!irq_mask[0]));
        end
        if (wake_timer_expired_flag && !wp) begin
            e = wq.size() > 0 ? wq.pop_front() : -1;
            check(16'(wt), 16'(e));
            check(16'(wake_cycle_tick), 16'(op_mode == rgw_pkg::RGW_MODE_WAKEUP));
            check(16'(irq), 16'(!irq_mask[1]));
            wt = 0;
        end
        if (rc_tick) wt++;
        gp <= gpt_expired_flag;
        wp <= wake_timer_expired_flag;
    end

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        // each trigger source, the wrong kind first
        for (int t = 1; t < 4; t++) begin
            @(posedge clk) p = 16'({$random(seed)} % 9);
            gpt_trig_sel <= rgw_pkg::rgw_trig_t'(t);
            op_mode <= t == 3 ? rgw_pkg::RGW_MODE_P2P_ACTIVE : rgw_pkg::RGW_MODE_NORMAL;
            gpt_period <= p;
            rx(t % 3 + 1);
            @(negedge clk) check(16'(gpt_running), 16'h0);
            rx(t);
            gq.push_back(k + (p == 0 ? 1 : p) + 4);
            drain();
        end
        // restart while running, then sticky flag under mask
        @(posedge clk) gpt_trig_sel <= rgw_pkg::RGW_TRIG_NONE;
        op_mode <= rgw_pkg::RGW_MODE_NORMAL;
        gpt_period <= 16'h0006;
        cmd(2'h0);
        repeat (3) @(posedge clk);
        cmd(2'h0);
        gq.push_back(k + 10);
        drain();
        @(posedge clk) ack_en <= 1'b0;
        irq_mask <= 2'h1;
        cmd(2'h0);
        gq.push_back(k + 10);
        drain();
        repeat (20) @(negedge clk);
        check(16'(gpt_expired_flag), 16'h1);
        check(16'(irq), 16'h0);
        @(posedge clk) irq_mask <= 2'h0;
        @(negedge clk) check(16'(irq), 16'h1);
        @(posedge clk) ack_en <= 1'b1;
        repeat (4) @(negedge clk);
        check(16'(gpt_expired_flag), 16'h0);
        check(16'(irq), 16'h0);
        // period 6: enable low for 5 edges, then crystal off for 3, stretch it by 8
        cmd(2'h0);
        @(posedge clk) clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
        xtal_ok <= 1'b0;
        repeat (3) @(posedge clk);
        xtal_ok <= 1'b1;
        gq.push_back(k + 18);
        drain();
        // one-shot wake in low power, every interval select, clear between
        for (int s = 0; s < 8; s++) begin
            @(posedge clk) op_mode <= rgw_pkg::RGW_MODE_LOW_POWER;
            wut_sel <= 3'(s);
            gpt_period <= 16'h0005;
            wt = 0;
            cmd(2'h0);
            cmd(2'h1);
            wq.push_back(4 << s);
            repeat (10) @(negedge clk);
            check(16'(gpt_running), 16'h1);
            check(gpt_count, 16'h0005);
            cmd(2'h2);
            repeat (2) @(negedge clk);
            check(16'(gpt_running), 16'h0);
            check(16'(wut_running && rc_osc_en), 16'h1);
            pump(4 << s);
            drain();
        end
        // periodic wake-up mode; start command mid-interval is ignored
        @(posedge clk) op_mode <= rgw_pkg::RGW_MODE_WAKEUP;
        wut_sel <= 3'h1;
        wt = 0;
        repeat (3) wq.push_back(8);
        pump(3);
        cmd(2'h1);
        pump(21);
        drain();
        @(posedge clk) op_mode <= rgw_pkg::RGW_MODE_NORMAL;
        repeat (2) @(negedge clk);
        check(16'({wut_running, rc_osc_en}), 16'h0);
        finish_test();
    end
endmodule : reader_gp_and_wake_timers_test

//--- testbench/rgw_ctrl_model.sv
`timescale 1ns/1ns
// controller model: direct commands and interrupt register reads
module rgw_ctrl_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [1:0] op,
    input wire logic ack_en,
    input wire logic irq,
    output logic cmd_start_gpt,
    output logic cmd_start_wut,
    output logic cmd_clear,
    output logic irq_read
);
    // one-cycle pulse per request; read back while irq stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {cmd_start_gpt, cmd_start_wut, cmd_clear, irq_read} <= 4'h0;
        end else begin
            cmd_start_gpt <= go && op == 2'h0;
            cmd_start_wut <= go && op == 2'h1;
            cmd_clear <= go && op == 2'h2;
            irq_read <= ack_en && irq && !irq_read;
        end
    end
endmodule : rgw_ctrl_model
